// File: test_ucp_command_port.sv
// Self-checking bench for the serial command port.
`default_nettype none

module test_ucp_command_port;
    timeunit 1ns;
    timeprecision 1ns;

    logic i_clk = 1'b0;
    logic i_rstn, i_restart, i_strap, i_cmd_done, rxd;
    logic [63:0] i_query_data;
    logic o_txd, o_cmd_valid, o_busy, o_frame_error;
    logic [7:0] o_cmd_addr;
    logic [55:0] o_cmd_data;
    logic [1:0] o_baud_code;
    logic [15:0] div_now;
    int miscompares = 0;
    int checks_done = 0;

    // 20 MHz clock
    always #25 i_clk = ~i_clk;

    ucp_command_port dut (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_restart(i_restart), .i_baud_select_strap(i_strap), .i_rxd(rxd),
        .i_cmd_done(i_cmd_done), .i_query_data(i_query_data), .o_txd(o_txd),
        .o_cmd_valid(o_cmd_valid), .o_cmd_addr(o_cmd_addr),
        .o_cmd_data(o_cmd_data), .o_busy(o_busy),
        .o_frame_error(o_frame_error), .o_baud_code(o_baud_code));
    ucp_host_model host (.i_clk(i_clk), .i_txd(o_txd), .i_div(div_now),
        .o_rxd(rxd));

    // Bit period in clocks for a rate code
    function automatic logic [15:0] exp_div(input logic [1:0] code);
        case (code)
            ucp_pkg::CODE_57600: return ucp_pkg::DIV_FIXED;
            ucp_pkg::CODE_115200: return ucp_pkg::DIV_DEFAULT;
            ucp_pkg::CODE_230400: return ucp_pkg::DIV_230K;
            default: return ucp_pkg::DIV_460K;
        endcase
    endfunction : exp_div

    // Answer length: eight bytes for queries, else one acknowledge
    function automatic int exp_len(input logic [7:0] a);
        return (a >= 8'h20 && a <= 8'h24) ? 8 : 1;
    endfunction : exp_len

    task automatic chk_val(input logic [63:0] got, input logic [63:0] exp,
                           input string what);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: %s got %h, expected %h", $time, what,
                     got, exp);
        end
    endtask : chk_val

    // Host follows the rate the port should now be using
    task automatic chk_code(input logic [1:0] exp);
        chk_val(64'(o_baud_code), 64'(exp), "rate code");
        div_now = exp_div(exp);
    endtask : chk_code

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic do_reset(input logic strap);
        i_strap = strap;
        i_rstn = 1'b0;
        repeat (4) @(posedge i_clk);
        #1;
        i_rstn = 1'b1;
        @(posedge i_clk);
        #1;
    endtask : do_reset

    task automatic pulse_restart();
        i_restart = 1'b1;
        @(posedge i_clk);
        #1;
        i_restart = 1'b0;
        @(posedge i_clk);
        #1;
    endtask : pulse_restart

    // One frame out; the core side and the answer are checked meanwhile
    task automatic run_cmd(input logic [7:0] a, input logic [55:0] d);
        logic [63:0] frame, q;
        logic [7:0] b;
        bit ok;
        int n;
        frame = {a, d};
        q = {$urandom, $urandom};
        n = 0;
        fork
            for (int i = 7; i >= 0; i--) begin
                host.send_byte(frame[i*8 +: 8]);
            end
            begin
                if (a != ucp_pkg::ADDR_BAUD) begin
                    // Look just after the edge so the pulse has settled
                    while (o_cmd_valid !== 1'b1 && n < 40000) begin
                        @(posedge i_clk);
                        #1;
                        n++;
                    end
                    chk_val(64'(o_cmd_addr), 64'(a), "address");
                    chk_val(64'(o_cmd_data), 64'(d), "data");
                    repeat (20) @(posedge i_clk);
                    #1;
                    i_query_data = q;
                    i_cmd_done = 1'b1;
                    @(posedge i_clk);
                    #1;
                    i_cmd_done = 1'b0;
                end
                for (int i = 0; i < exp_len(a); i++) begin
                    host.recv_byte(b, ok);
                    chk_val(64'(ok), 64'h1, "stop bit");
                    chk_val(64'(b), 64'(exp_len(a) == 8 ? q[63-8*i -: 8] :
                        ucp_pkg::ACK_BYTE), "answer");
                end
            end
        join
        n = 0;
        while (o_busy !== 1'b0 && n < 1000) begin
            @(posedge i_clk);
            n++;
        end
        #1;
        chk_val(64'(o_busy), 64'h0, "busy after answer");
    endtask : run_cmd

    // Character with a low stop bit: must flag and then be forgotten
    task automatic bad_stop();
        int n;
        n = 0;
        fork
            host.send_bits({1'b0, 8'($urandom), 1'b0});
            while (o_frame_error !== 1'b1 && n < 1000) begin
                @(posedge i_clk);
                #1;
                n++;
            end
        join
        chk_val(64'(n < 1000), 64'h1, "frame error pulse");
        // Let the receiver drop the false start before the next frame
        repeat (div_now) @(posedge i_clk);
        #1;
    endtask : bad_stop

    // Cuts a hang short; the planned run is about 89k cycles
    initial begin
        repeat (100000) @(posedge i_clk);
        miscompares++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        logic [7:0] a;
        logic [55:0] d;
        i_rstn = 1'b0;
        i_restart = 1'b0;
        i_strap = 1'b1;
        i_cmd_done = 1'b0;
        i_query_data = 64'h0;
        div_now = ucp_pkg::DIV_DEFAULT;
        void'($urandom(32'hBF8E));
        do_reset(1'b1);
        chk_code(ucp_pkg::CODE_115200);
        run_cmd(ucp_pkg::ADDR_BAUD, 56'h3);
        chk_code(ucp_pkg::CODE_115200);
        pulse_restart();
        chk_code(ucp_pkg::CODE_460800);
        for (int q = 8'h20; q <= 8'h24; q++) begin
            d = (q == 8'h20) ? 56'h1 : 56'({$urandom, $urandom});
            run_cmd(8'(q), d);
        end
        a = 8'($urandom_range(8'h1F, 8'h00));
        a = (a == ucp_pkg::ADDR_BAUD) ? 8'h10 : a;
        run_cmd(a, 56'({$urandom, $urandom}));
        bad_stop();
        run_cmd(8'h10, 56'({$urandom, $urandom}));
        i_strap = 1'b0;
        @(posedge i_clk);
        #1;
        chk_code(ucp_pkg::CODE_460800);
        pulse_restart();
        chk_code(ucp_pkg::CODE_57600);
        run_cmd(ucp_pkg::ADDR_BAUD, 56'h2);
        chk_code(ucp_pkg::CODE_57600);
        i_strap = 1'b1;
        pulse_restart();
        chk_code(ucp_pkg::CODE_230400);
        do_reset(1'b1);
        chk_code(ucp_pkg::CODE_115200);
        do_reset(1'b0);
        chk_code(ucp_pkg::CODE_57600);
        report_and_stop();
    end
endmodule : test_ucp_command_port

`default_nettype wire

// File: ucp_bit_timer.sv
// Constants package and bit timer for the serial command port.
`default_nettype none

package ucp_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int BAUD_FIXED = 57600;
    localparam int BAUD_DEFAULT = 115200;
    localparam int BAUD_230K = 230400;
    localparam int BAUD_460K = 460800;
    localparam int DIV_W = 16;
    // Clock cycles per bit, rounded down
    localparam logic [15:0] DIV_FIXED = 16'(CLK_HZ / BAUD_FIXED);
    localparam logic [15:0] DIV_DEFAULT = 16'(CLK_HZ / BAUD_DEFAULT);
    localparam logic [15:0] DIV_230K = 16'(CLK_HZ / BAUD_230K);
    localparam logic [15:0] DIV_460K = 16'(CLK_HZ / BAUD_460K);
    // Baud code held in the low bits of the baud configuration register
    localparam logic [1:0] CODE_57600 = 2'h0;
    localparam logic [1:0] CODE_115200 = 2'h1;
    localparam logic [1:0] CODE_230400 = 2'h2;
    localparam logic [1:0] CODE_460800 = 2'h3;
    localparam logic [1:0] CODE_RESET = 2'h1;
    // Command addresses and answer
    localparam logic [7:0] ADDR_BAUD = 8'h15;
    localparam logic [7:0] ADDR_QUERY_FIRST = 8'h20;
    localparam logic [7:0] ADDR_QUERY_LAST = 8'h24;
    localparam logic [7:0] ACK_BYTE = 8'h01;
    // Frame shape
    localparam logic [2:0] LAST_FRAME_BYTE = 3'h7;
    localparam logic [3:0] QUERY_BYTES = 4'h8;
    localparam logic [3:0] ACK_BYTES = 4'h1;
    localparam logic [2:0] LAST_DATA_BIT = 3'h7;
    localparam logic [3:0] LAST_TX_BIT = 4'h9;
endpackage : ucp_pkg

// Bit timer: pulses at mid bit and at bit end, restartable
module ucp_bit_timer (
    input wire logic i_clk,                      // System clock
    input wire logic i_rstn,                     // Sync reset, active low
    input wire logic i_restart,                  // Restart the bit period
    input wire logic [ucp_pkg::DIV_W-1:0] i_div, // Cycles per bit
    output logic o_half,                         // Mid-bit pulse
    output logic o_full                          // End-of-bit pulse
);
    logic [ucp_pkg::DIV_W-1:0] cnt_reg, cnt_next;
    logic half_reg, half_next, full_reg, full_next;

    // Count the bit period; pulses are registered so they lag one cycle
    always_comb begin
        half_next = 1'b0;
        full_next = 1'b0;
        cnt_next = cnt_reg + 16'h0001;
        if (i_restart) begin
            cnt_next = 16'h0000;
        end else if (cnt_reg == i_div - 16'h0001) begin
            cnt_next = 16'h0000;
            full_next = 1'b1;
        end else if (cnt_reg == (i_div >> 1)) begin
            half_next = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            cnt_reg <= 16'h0000;
            half_reg <= 1'b0;
            full_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            half_reg <= half_next;
            full_reg <= full_next;
        end
    end

    assign o_half = half_reg;
    assign o_full = full_reg;
endmodule : ucp_bit_timer

`default_nettype wire

// File: ucp_command_port.sv
// Serial command port: 8-byte commands in, acknowledge or query data out.
//
// How it works
// - Strap low at reset or restart forces a fixed 57600 baud regardless of programmed rate.
// - Strap high uses the rate stored by writing address 0x15.
// - Strap high with nothing programmed runs at 115200 baud.
// - A programmed rate waits for a restart before it applies; reset clears it back to 115200.
// - Characters are 8 data bits, no parity, one stop bit, no flow control.
// - Command data bytes arrive most significant first.
// - A write to addresses 0x20 to 0x24 returns exactly 8 bytes.
// - Any other completed write returns one acknowledge byte 0x01.
// - Query data goes out most significant byte first, right aligned.
// - Writing 0x01 to 0x20 returns the current output frequency.
`default_nettype none

module ucp_command_port (
    input wire logic i_clk,                  // 20 MHz system clock
    input wire logic i_rstn,                 // Sync reset, active low
    input wire logic i_restart,              // Soft restart pulse
    input wire logic i_baud_select_strap,    // Low: fixed rate
    input wire logic i_rxd,                  // Serial data from host
    input wire logic i_cmd_done,             // Core finished the command
    input wire logic [63:0] i_query_data,    // Query answer, valid at done
    output logic o_txd,                      // Serial data to host
    output logic o_cmd_valid,                // One-cycle command pulse
    output logic [7:0] o_cmd_addr,           // Register address
    output logic [55:0] o_cmd_data,          // Register data
    output logic o_busy,                     // Command in progress
    output logic o_frame_error,              // Bad stop bit pulse
    output logic [1:0] o_baud_code           // Rate now in use
);
    typedef enum logic [3:0] {
        RX_IDLE = 4'h1,
        RX_START = 4'h2,
        RX_DATA = 4'h4,
        RX_STOP = 4'h8
    } ucp_rx_type;

    typedef enum logic [3:0] {
        M_COLLECT = 4'h1,
        M_ISSUE = 4'h2,
        M_WAIT = 4'h4,
        M_SEND = 4'h8
    } ucp_main_type;

    // Baud selection state
    logic [1:0] pend_code_reg, pend_code_next;
    logic [1:0] act_code_reg, act_code_next;
    logic [15:0] div_reg, div_next;

    // Receiver state
    ucp_rx_type rx_state_reg, rx_state_next;
    logic [7:0] rx_shift_reg, rx_shift_next;
    logic [2:0] rx_bit_reg, rx_bit_next;
    logic rx_valid_reg, rx_valid_next;
    logic ferr_reg, ferr_next;
    logic rx_half, rx_full, rx_restart;

    // Command state
    ucp_main_type m_state_reg, m_state_next;
    logic [63:0] frame_reg, frame_next;
    logic [2:0] frame_cnt_reg, frame_cnt_next;
    logic cmd_valid_reg, cmd_valid_next;
    logic busy_reg, busy_next;
    logic [63:0] out_buf_reg, out_buf_next;
    logic [3:0] out_left_reg, out_left_next;

    // Transmitter state
    logic [9:0] tx_shift_reg, tx_shift_next;
    logic [3:0] tx_bit_reg, tx_bit_next;
    logic tx_active_reg, tx_active_next;
    logic txd_reg, txd_next;
    logic tx_full, tx_load;

    // Map a baud code to its bit period
    function automatic logic [15:0] code_div(input logic [1:0] code);
        logic [15:0] d;
        case (code)
            ucp_pkg::CODE_57600: d = ucp_pkg::DIV_FIXED;
            ucp_pkg::CODE_115200: d = ucp_pkg::DIV_DEFAULT;
            ucp_pkg::CODE_230400: d = ucp_pkg::DIV_230K;
            ucp_pkg::CODE_460800: d = ucp_pkg::DIV_460K;
            default: d = ucp_pkg::DIV_DEFAULT;
        endcase
        return d;
    endfunction : code_div

    // Rate is chosen only at reset or restart, so a running link never
    // changes speed mid-character
    always_comb begin
        act_code_next = act_code_reg;
        if (i_restart) begin
            if (!i_baud_select_strap) begin
                act_code_next = ucp_pkg::CODE_57600;
            end else begin
                act_code_next = pend_code_reg;
            end
        end
        div_next = code_div(act_code_next);
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            // Strap is a plain synchronous input, sampled during reset
            if (!i_baud_select_strap) begin
                act_code_reg <= ucp_pkg::CODE_57600;
                div_reg <= ucp_pkg::DIV_FIXED;
            end else begin
                act_code_reg <= ucp_pkg::CODE_115200;
                div_reg <= ucp_pkg::DIV_DEFAULT;
            end
        end else begin
            act_code_reg <= act_code_next;
            div_reg <= div_next;
        end
    end

    ucp_bit_timer u_rx_timer (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_restart(rx_restart),
        .i_div(div_reg),
        .o_half(rx_half),
        .o_full(rx_full)
    );

    // Receiver: start bit checked at mid bit, 8 data bits LSB first
    always_comb begin
        rx_state_next = rx_state_reg;
        rx_shift_next = rx_shift_reg;
        rx_bit_next = rx_bit_reg;
        rx_valid_next = 1'b0;
        ferr_next = 1'b0;
        rx_restart = 1'b0;
        case (rx_state_reg)
            RX_IDLE: begin
                if (!i_rxd) begin
                    rx_restart = 1'b1;
                    rx_state_next = RX_START;
                end
            end
            RX_START: begin
                if (rx_half) begin
                    if (!i_rxd) begin
                        // Realign so later end pulses hit bit centres
                        rx_restart = 1'b1;
                        rx_bit_next = 3'h0;
                        rx_state_next = RX_DATA;
                    end else begin
                        rx_state_next = RX_IDLE;         // Glitch
                    end
                end
            end
            RX_DATA: begin
                if (rx_full) begin
                    rx_shift_next = {i_rxd, rx_shift_reg[7:1]};
                    rx_bit_next = rx_bit_reg + 3'h1;
                    if (rx_bit_reg == ucp_pkg::LAST_DATA_BIT) begin
                        rx_state_next = RX_STOP;         // No parity
                    end
                end
            end
            RX_STOP: begin
                if (rx_full) begin
                    rx_valid_next = i_rxd;
                    ferr_next = !i_rxd;
                    rx_state_next = RX_IDLE;
                end
            end
            default: rx_state_next = RX_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rx_state_reg <= RX_IDLE;
            rx_shift_reg <= 8'h00;
            rx_bit_reg <= 3'h0;
            rx_valid_reg <= 1'b0;
            ferr_reg <= 1'b0;
        end else begin
            rx_state_reg <= rx_state_next;
            rx_shift_reg <= rx_shift_next;
            rx_bit_reg <= rx_bit_next;
            rx_valid_reg <= rx_valid_next;
            ferr_reg <= ferr_next;
        end
    end

    // Command handling; bytes landing while busy are dropped since
    // the host waits for the answer before sending more
    always_comb begin
        m_state_next = m_state_reg;
        frame_next = frame_reg;
        frame_cnt_next = frame_cnt_reg;
        cmd_valid_next = 1'b0;
        busy_next = busy_reg;
        out_buf_next = out_buf_reg;
        out_left_next = out_left_reg;
        pend_code_next = pend_code_reg;
        tx_load = 1'b0;
        case (m_state_reg)
            M_COLLECT: begin
                if (rx_valid_reg) begin
                    // First byte ends up on top: address, then data MSB
                    frame_next = {frame_reg[55:0], rx_shift_reg};
                    frame_cnt_next = frame_cnt_reg + 3'h1;
                    if (frame_cnt_reg == ucp_pkg::LAST_FRAME_BYTE) begin
                        busy_next = 1'b1;
                        if (frame_reg[55:48] == ucp_pkg::ADDR_BAUD) begin
                            pend_code_next = rx_shift_reg[1:0];
                            out_buf_next = {ucp_pkg::ACK_BYTE, 56'h0};
                            out_left_next = ucp_pkg::ACK_BYTES;
                            m_state_next = M_SEND;
                        end else begin
                            m_state_next = M_ISSUE;
                        end
                    end
                end
            end
            M_ISSUE: begin
                cmd_valid_next = 1'b1;
                m_state_next = M_WAIT;
            end
            M_WAIT: begin
                if (i_cmd_done) begin
                    if (frame_reg[63:56] >= ucp_pkg::ADDR_QUERY_FIRST &&
                        frame_reg[63:56] <= ucp_pkg::ADDR_QUERY_LAST) begin
                        out_buf_next = i_query_data;
                        out_left_next = ucp_pkg::QUERY_BYTES;
                    end else begin
                        out_buf_next = {ucp_pkg::ACK_BYTE, 56'h0};
                        out_left_next = ucp_pkg::ACK_BYTES;
                    end
                    m_state_next = M_SEND;
                end
            end
            M_SEND: begin
                if (!tx_active_reg) begin
                    if (out_left_reg == 4'h0) begin
                        busy_next = 1'b0;
                        m_state_next = M_COLLECT;
                    end else begin
                        tx_load = 1'b1;
                        out_buf_next = {out_buf_reg[55:0], 8'h00};
                        out_left_next = out_left_reg - 4'h1;
                    end
                end
            end
            default: m_state_next = M_COLLECT;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            m_state_reg <= M_COLLECT;
            frame_reg <= 64'h0;
            frame_cnt_reg <= 3'h0;
            cmd_valid_reg <= 1'b0;
            busy_reg <= 1'b0;
            out_buf_reg <= 64'h0;
            out_left_reg <= 4'h0;
            pend_code_reg <= ucp_pkg::CODE_RESET;
        end else begin
            m_state_reg <= m_state_next;
            frame_reg <= frame_next;
            frame_cnt_reg <= frame_cnt_next;
            cmd_valid_reg <= cmd_valid_next;
            busy_reg <= busy_next;
            out_buf_reg <= out_buf_next;
            out_left_reg <= out_left_next;
            pend_code_reg <= pend_code_next;
        end
    end

    ucp_bit_timer u_tx_timer (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_restart(tx_load),
        .i_div(div_reg),
        .o_half(),
        .o_full(tx_full)
    );

    // Transmitter: start, 8 data LSB first, one stop; no flow control
    always_comb begin
        tx_shift_next = tx_shift_reg;
        tx_bit_next = tx_bit_reg;
        tx_active_next = tx_active_reg;
        txd_next = txd_reg;
        if (tx_load) begin
            tx_shift_next = {1'b1, out_buf_reg[63:56], 1'b0};
            tx_bit_next = 4'h0;
            tx_active_next = 1'b1;
            txd_next = 1'b0;
        end else if (tx_active_reg && tx_full) begin
            if (tx_bit_reg == ucp_pkg::LAST_TX_BIT) begin
                tx_active_next = 1'b0;
                txd_next = 1'b1;
            end else begin
                tx_shift_next = {1'b1, tx_shift_reg[9:1]};
                tx_bit_next = tx_bit_reg + 4'h1;
                txd_next = tx_shift_reg[1];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            tx_shift_reg <= 10'h3FF;
            tx_bit_reg <= 4'h0;
            tx_active_reg <= 1'b0;
            txd_reg <= 1'b1;
        end else begin
            tx_shift_reg <= tx_shift_next;
            tx_bit_reg <= tx_bit_next;
            tx_active_reg <= tx_active_next;
            txd_reg <= txd_next;
        end
    end

    // All outputs straight from flip-flops
    assign o_txd = txd_reg;
    assign o_cmd_valid = cmd_valid_reg;
    assign o_cmd_addr = frame_reg[63:56];
    assign o_cmd_data = frame_reg[55:0];
    assign o_busy = busy_reg;
    assign o_frame_error = ferr_reg;
    assign o_baud_code = act_code_reg;
endmodule : ucp_command_port

`default_nettype wire

// File: ucp_command_port_chk.sv
// Concurrent checks on the ports of the serial command port.
`default_nettype none

module ucp_command_port_chk (
    input wire logic i_clk,               // System clock
    input wire logic i_rstn,              // Sync reset, active low
    input wire logic i_restart,           // Restart pulse
    input wire logic i_baud_select_strap, // Rate strap
    input wire logic i_rxd,               // Serial data from host
    input wire logic i_cmd_done,          // Core finished
    input wire logic [63:0] i_query_data, // Query answer
    input wire logic o_txd,               // Serial data to host
    input wire logic o_cmd_valid,         // Command pulse
    input wire logic [7:0] o_cmd_addr,    // Register address
    input wire logic [55:0] o_cmd_data,   // Register data
    input wire logic o_busy,              // Command in progress
    input wire logic o_frame_error,       // Bad stop bit pulse
    input wire logic [1:0] o_baud_code    // Rate in use
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    // Start bit of an answer
    sequence tx_start;
        $fell(o_txd);
    endsequence
    // Line held idle for 8 cycles while the core starts on the command
    sequence tx_quiet;
        o_txd [*8];
    endsequence

    a_reset_fixed_rate: assert property ($rose(i_rstn)
        && !$past(i_baud_select_strap) |-> o_baud_code == 2'h0)
        else $error("fixed rate not chosen after reset");
    a_reset_default_rate: assert property ($rose(i_rstn)
        && $past(i_baud_select_strap) |-> o_baud_code == 2'h1)
        else $error("default rate not chosen after reset");
    a_restart_fixed_rate: assert property (i_restart
        && !i_baud_select_strap |=> o_baud_code == 2'h0)
        else $error("restart with strap low kept another rate");
    a_rate_held: assert property (!i_restart |=> $stable(o_baud_code))
        else $error("rate changed without restart");
    a_valid_after_frame: assert property (o_cmd_valid |-> $past(o_busy)
        && o_cmd_addr != ucp_pkg::ADDR_BAUD)
        else $error("command pulse without a received frame");
    a_valid_single: assert property (o_cmd_valid |=> !o_cmd_valid)
        else $error("command pulse longer than one cycle");
    a_answer_waits: assert property (o_cmd_valid |-> tx_quiet)
        else $error("answer started before the core finished");
    a_answer_after_done: assert property (i_cmd_done && o_busy
        |-> ##[1:3] tx_start)
        else $error("answer did not start after core done");
    a_idle_line_high: assert property (!o_busy |-> o_txd)
        else $error("line not idle while port is free");
    a_busy_on_stop: assert property ($rose(o_busy) |-> $past(i_rxd))
        else $error("busy rose without a stop bit");
endmodule : ucp_command_port_chk

bind ucp_command_port ucp_command_port_chk chk (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_restart(i_restart),
    .i_baud_select_strap(i_baud_select_strap), .i_rxd(i_rxd),
    .i_cmd_done(i_cmd_done), .i_query_data(i_query_data), .o_txd(o_txd),
    .o_cmd_valid(o_cmd_valid), .o_cmd_addr(o_cmd_addr),
    .o_cmd_data(o_cmd_data), .o_busy(o_busy),
    .o_frame_error(o_frame_error), .o_baud_code(o_baud_code));

`default_nettype wire

// File: ucp_host_model.sv
// Host side model: sends and receives 8N1 characters.
`default_nettype none

module ucp_host_model (
    input wire logic i_clk,        // System clock, timing only
    input wire logic i_txd,        // Serial data from the device
    input wire logic [15:0] i_div, // Clock cycles per bit
    output logic o_rxd             // Serial data to the device
);
    timeunit 1ns;
    timeprecision 1ns;

    // Line idles high between characters
    initial o_rxd = 1'b1;

    // Start bit, data LSB first, one stop bit, no flow control
    task automatic send_byte(input logic [7:0] b);
        send_bits({1'b1, b, 1'b0});
    endtask : send_byte

    // Raw character, LSB first; line left idle high so the false start
    // after a bad stop bit is dropped as a glitch
    task automatic send_bits(input logic [9:0] bits);
        for (int i = 0; i < 10; i++) begin
            o_rxd = bits[i];
            repeat (i_div) @(posedge i_clk);
            #1;
        end
        o_rxd = 1'b1;
    endtask : send_bits

    // Bounded wait for a start bit; a silent device reads as failure
    task automatic recv_byte(output logic [7:0] b, output bit ok);
        int n;
        n = 0;
        b = 8'h00;
        while (i_txd !== 1'b0 && n < 40000) begin
            @(posedge i_clk);
            n++;
        end
        repeat (i_div / 2) @(posedge i_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (i_div) @(posedge i_clk);
            b[i] = i_txd;
        end
        repeat (i_div) @(posedge i_clk);
        ok = (n < 40000) && (i_txd === 1'b1);
    endtask : recv_byte
endmodule : ucp_host_model

`default_nettype wire
